// ### verilog/ifs_defs.vh
`ifndef IFS_DEFS_VH
`define IFS_DEFS_VH
// Section framing constants
`define IFS_TABLE_ID      8'h79
`define IFS_DESC_TAG      8'h77
`define IFS_HDR_BYTES     12'd12
`define IFS_LEN_OVERHEAD  12'd13
`define IFS_CRC_BYTES     12'd4
`define IFS_CRC_POLY      32'h04c11db7
`define IFS_CRC_INIT      32'hffffffff
`define IFS_SEL_BYTES     8'h08
`define IFS_DESC_FIXED    8'h03
`define IFS_SCHEME_SEL    4'h1
`define IFS_DUR_UNUSED    8'hff
// Delay units: signalled delay step 10 ms, burst duration step 20 ms
`define IFS_DELTA_UNIT_MS 10
`define IFS_DUR_UNIT_MS   20
// Register word indices (byte address bits 4:2)
`define IFS_REG_CTRL      4'h0
`define IFS_REG_DESC      4'h1
`define IFS_REG_DELTA     4'h2
`define IFS_REG_PREV      4'h3
`define IFS_REG_BSIZE     4'h4
`define IFS_REG_SEL_LO    4'h5
`define IFS_REG_SEL_HI    4'h6
`define IFS_REG_STATUS    4'h7
// CTRL fields
`define IFS_CTRL_TS       0
`define IFS_CTRL_FEC_LO   1
`define IFS_CTRL_FS_LO    3
`define IFS_CTRL_DGO      6
`define IFS_CTRL_CLR      7
// Reset values
`define IFS_CTRL_RST      32'h00000000
`define IFS_DESC_RST      32'h0001ffff
`endif

// ### verilog/ifs_crc32.v
`timescale 1ns/100ps
`default_nettype none
module ifs_crc32 (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        init,
   input  wire        en,
   input  wire [7:0]  data,
   output reg  [31:0] crc_q
);
`include "ifs_defs.vh"
   reg [31:0] crc_d;
   reg [31:0] c;
   integer    i;

   // Non-reflected, MSB-first byte update
   always @* begin
      // Seed and first byte can meet in one cycle, so the seed feeds the update
      c = init ? `IFS_CRC_INIT : crc_q;
      for (i = 7; i >= 0; i = i - 1) begin
         if (c[31] ^ data[i]) begin
            c = {c[30:0], 1'b0} ^ `IFS_CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      crc_d = c;
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crc_q <= `IFS_CRC_INIT;
      end else if (en) begin
         crc_q <= crc_d;
      end else if (init) begin
         crc_q <= `IFS_CRC_INIT;
      end
   end
endmodule
`default_nettype wire

// ### verilog/ifs_section_framer.v
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Section table id byte is 0x79
// - Syntax indicator one, private indicator zero
// - Reserved header bits all driven ones
// - Current/next indicator always one
// - Length counts bytes after it incl CRC
// - Burst number wraps at kmax below 256
// - Append 32-bit section CRC over section
// - Burst size same in every section
// - Real-time word: delay, flags, previous size
// - Delay in 10 ms units when sliced
// - Delay measured packet start to burst
// - Zero delay means no further bursts
// - Delay exceeds maximum burst duration
// - Unsliced: cyclic sub-table index, wraps
// - Data-end flag when no data follows
// - Last-parity flag only final section
// - Descriptor tag 0x77 then fields ordered
// - Descriptor length counts following bytes
// - Time slicing bit selects delay meaning
// - FEC mode 00/01 only, reserved never
// - Descriptor reserved pair driven ones
// - Frame size carries burst and rows
// - Header field layout and widths fixed
module ifs_section_framer #(
   parameter CLK_MHZ = 10
) (
   input  wire        clock,
   input  wire        rst_n,
   // Avalon-MM slave
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Section request from parity logic
   input  wire        sec_valid,
   input  wire [11:0] sec_payload_len,
   input  wire [7:0]  sec_index,
   input  wire [7:0]  sec_max_col,
   input  wire        sec_data_end,
   output reg         sec_ready,
   // Payload bytes
   input  wire        pay_valid,
   input  wire [7:0]  pay_data,
   output reg         pay_ready,
   // Byte stream toward the multiplexer
   output reg         out_valid,
   output reg  [7:0]  out_data,
   output reg         out_first,
   output reg         out_last,
   output reg         out_desc,
   input  wire        out_ready
);
`include "ifs_defs.vh"
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_HDR  = 5'b00010;
   localparam [4:0] S_PAY  = 5'b00100;
   localparam [4:0] S_CRC  = 5'b01000;
   localparam [4:0] S_DSC  = 5'b10000;

   reg  [4:0]  state_q;
   reg  [11:0] cnt_q;
   reg  [31:0] ctrl_q;
   reg  [31:0] desc_q;
   reg  [11:0] delta_q;
   reg  [17:0] prev_q;
   reg  [7:0]  bsize_q;
   reg  [63:0] sel_q;
   reg         dgo_q;
   reg  [7:0]  bn_q;
   reg  [11:0] cidx_q;
   reg  [7:0]  sent_q;
   reg  [11:0] plen_q;
   reg  [7:0]  idx_q;
   reg  [7:0]  mcol_q;
   reg         dend_q;
   reg  [31:0] rtp_q;
   reg         crc_init_q;
   wire [31:0] crc;

   wire        ts      = ctrl_q[`IFS_CTRL_TS];
   wire [1:0]  fec     = ctrl_q[`IFS_CTRL_FEC_LO+1:`IFS_CTRL_FEC_LO];
   wire [2:0]  fsize   = ctrl_q[`IFS_CTRL_FS_LO+2:`IFS_CTRL_FS_LO];
   wire [7:0]  dur     = desc_q[7:0];
   wire [3:0]  rate    = desc_q[11:8];
   wire [3:0]  scheme  = desc_q[15:12];
   wire [7:0]  ep_raw  = desc_q[23:16];
   wire [7:0]  ep      = (ep_raw == 8'h00) ? 8'h01 : ep_raw;
   wire        has_sel = (scheme == `IFS_SCHEME_SEL);

   wire [7:0]  kmax    = 8'hff - (8'hff % ep);
   wire [7:0]  bn_next = (bn_q >= kmax - 8'h01) ? 8'h00 : bn_q + 8'h01;

   // shortest delay that clears the burst window (units of 10 ms)
   wire [11:0] min_dt  = {3'b000, dur, 1'b0} + 12'd3;
   wire [11:0] dt_ts   = (delta_q != 12'h000 && delta_q < min_dt) ? min_dt : delta_q;
   wire [11:0] dt_fld  = ts ? dt_ts : cidx_q;

   // length counts everything after the length field
   wire [11:0] sec_len = plen_q + `IFS_LEN_OVERHEAD;
   wire        last_sec = (idx_q == bsize_q - 8'h01);
   wire [7:0]  dlen    = `IFS_DESC_FIXED + (has_sel ? `IFS_SEL_BYTES : 8'h00);
   wire [7:0]  dur_eff = ts ? dur : `IFS_DUR_UNUSED;

   // Handshake and slot bookkeeping; output accepts only from an empty slot
   wire        slot    = !out_valid && !pay_ready;
   wire        take_p  = pay_ready && pay_valid;
   wire        sec_go  = sec_valid && sec_ready;

   reg  [7:0]  hdr_b;
   reg  [7:0]  dsc_b;
   wire [11:0] pay_end = `IFS_HDR_BYTES + plen_q;
   wire [11:0] crc_i   = cnt_q - pay_end;

   // fixed field order, most significant bit first
   always @* begin
      case (cnt_q[3:0])
         4'h0: hdr_b = `IFS_TABLE_ID;
         4'h1: hdr_b = {1'b1, 1'b0, 2'b11, sec_len[11:8]};
         4'h2: hdr_b = sec_len[7:0];
         4'h3: hdr_b = bn_q;
         4'h4: hdr_b = {7'h7f, 1'b1};
         4'h5: hdr_b = idx_q;
         4'h6: hdr_b = mcol_q;
         4'h7: hdr_b = bsize_q;
         4'h8: hdr_b = rtp_q[31:24];
         4'h9: hdr_b = rtp_q[23:16];
         4'ha: hdr_b = rtp_q[15:8];
         4'hb: hdr_b = rtp_q[7:0];
         default: hdr_b = 8'h00;
      endcase
   end

   always @* begin
      case (cnt_q[3:0])
         4'h0: dsc_b = `IFS_DESC_TAG;
         4'h1: dsc_b = dlen;
         // mode, reserved pair ones, frame size
         4'h2: dsc_b = {ts, fec, 2'b11, fsize};
         4'h3: dsc_b = dur_eff;
         4'h4: dsc_b = {rate, scheme};
         4'h5: dsc_b = sel_q[63:56];
         4'h6: dsc_b = sel_q[55:48];
         4'h7: dsc_b = sel_q[47:40];
         4'h8: dsc_b = sel_q[39:32];
         4'h9: dsc_b = sel_q[31:24];
         4'ha: dsc_b = sel_q[23:16];
         4'hb: dsc_b = sel_q[15:8];
         4'hc: dsc_b = sel_q[7:0];
         default: dsc_b = 8'h00;
      endcase
   end

   wire        hdr_ld  = state_q[1] && slot;
   wire        crc_ld  = state_q[3] && slot;
   wire        dsc_ld  = state_q[4] && slot;
   wire        sec_end = crc_ld && (crc_i == 12'd3);

   ifs_crc32 u_crc (
      .clock (clock),
      .rst_n (rst_n),
      .init  (crc_init_q),
      .en    (hdr_ld || take_p),
      .data  (take_p ? pay_data : hdr_b),
      .crc_q (crc)
   );

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= S_IDLE;
         cnt_q      <= 12'h000;
         sec_ready  <= 1'b0;
         pay_ready  <= 1'b0;
         out_valid  <= 1'b0;
         out_data   <= 8'h00;
         out_first  <= 1'b0;
         out_last   <= 1'b0;
         out_desc   <= 1'b0;
         plen_q     <= 12'h000;
         idx_q      <= 8'h00;
         mcol_q     <= 8'h00;
         dend_q     <= 1'b0;
         rtp_q      <= 32'h00000000;
         crc_init_q <= 1'b0;
         bn_q       <= 8'h00;
         cidx_q     <= 12'h000;
         sent_q     <= 8'h00;
      end else begin
         crc_init_q <= 1'b0;
         if (out_valid && out_ready) begin
            out_valid <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               sec_ready <= !dgo_q && !sec_go;
               if (dgo_q && !sec_ready) begin
                  state_q <= S_DSC;
                  cnt_q   <= 12'h000;
               end else if (sec_go) begin
                  sec_ready  <= 1'b0;
                  plen_q     <= sec_payload_len;
                  idx_q      <= sec_index;
                  mcol_q     <= sec_max_col;
                  dend_q     <= sec_data_end;
                  crc_init_q <= 1'b1;
                  cnt_q      <= 12'h000;
                  state_q    <= S_HDR;
               end
            end
            S_HDR: begin
               if (hdr_ld) begin
                  out_valid <= 1'b1;
                  out_data  <= hdr_b;
                  out_first <= (cnt_q == 12'h000);
                  out_last  <= 1'b0;
                  out_desc  <= 1'b0;
                  cnt_q     <= cnt_q + 12'h001;
                  if (cnt_q == `IFS_HDR_BYTES - 12'h001) begin
                     state_q <= (plen_q == 12'h000) ? S_CRC : S_PAY;
                  end
               end
               if (cnt_q == 12'h000) begin
                  rtp_q <= {dt_fld, dend_q, last_sec, prev_q};
               end
            end
            S_PAY: begin
               if (slot) begin
                  pay_ready <= 1'b1;
               end
               if (take_p) begin
                  pay_ready <= 1'b0;
                  out_valid <= 1'b1;
                  out_data  <= pay_data;
                  out_first <= 1'b0;
                  cnt_q     <= cnt_q + 12'h001;
                  if (cnt_q == pay_end - 12'h001) begin
                     state_q <= S_CRC;
                  end
               end
            end
            S_CRC: begin
               if (crc_ld) begin
                  out_valid <= 1'b1;
                  out_first <= 1'b0;
                  out_last  <= (crc_i == 12'd3);
                  cnt_q     <= cnt_q + 12'h001;
                  case (crc_i[1:0])
                     2'd0:    out_data <= crc[31:24];
                     2'd1:    out_data <= crc[23:16];
                     2'd2:    out_data <= crc[15:8];
                     default: out_data <= crc[7:0];
                  endcase
               end
               if (sec_end) begin
                  state_q <= S_IDLE;
                  if (last_sec) begin
                     bn_q   <= bn_next;
                     cidx_q <= cidx_q + 12'h001;
                     sent_q <= 8'h00;
                  end else begin
                     sent_q <= sent_q + 8'h01;
                  end
               end
            end
            S_DSC: begin
               if (dsc_ld) begin
                  out_valid <= 1'b1;
                  out_data  <= dsc_b;
                  out_first <= (cnt_q == 12'h000);
                  out_desc  <= 1'b1;
                  out_last  <= (cnt_q[7:0] == dlen + 8'h01);
                  cnt_q     <= cnt_q + 12'h001;
                  if (cnt_q[7:0] == dlen + 8'h01) begin
                     state_q <= S_IDLE;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
         // Counter clear from software; idle only, so a section in flight keeps its fields
         if (ctrl_q[`IFS_CTRL_CLR] && state_q[0]) begin
            bn_q   <= 8'h00;
            cidx_q <= 12'h000;
            sent_q <= 8'h00;
         end
      end
   end

   // Register slave: every access answers on the second cycle
   wire [3:0]  ridx  = {1'b0, avs_address[4:2]};
   wire        req   = avs_read || avs_write;
   wire        wr_ok = avs_write && !avs_waitrequest;
   reg  [31:0] rmux;
   wire [31:0] be_m  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   always @* begin
      case (ridx)
         `IFS_REG_CTRL:   rmux = {24'h000000, ctrl_q[7:6], ctrl_q[5:0]};
         `IFS_REG_DESC:   rmux = {8'h00, desc_q[23:0]};
         `IFS_REG_DELTA:  rmux = {20'h00000, delta_q};
         `IFS_REG_PREV:   rmux = {14'h0000, prev_q};
         `IFS_REG_BSIZE:  rmux = {24'h000000, bsize_q};
         `IFS_REG_SEL_LO: rmux = sel_q[31:0];
         `IFS_REG_SEL_HI: rmux = sel_q[63:32];
         `IFS_REG_STATUS: rmux = {3'b000, !state_q[0], sent_q, cidx_q, bn_q};
         default:         rmux = 32'h00000000;
      endcase
   end

   wire [31:0] wmrg = merge(rmux, avs_writedata, be_m);
   reg [31:0] cw;
   always @* begin
      cw = merge(ctrl_q, avs_writedata, be_m);
      // reserved mode codes are never stored
      if (cw[`IFS_CTRL_FEC_LO+1]) begin
         cw[`IFS_CTRL_FEC_LO+1:`IFS_CTRL_FEC_LO] = 2'b00;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         ctrl_q          <= `IFS_CTRL_RST;
         desc_q          <= `IFS_DESC_RST;
         delta_q         <= 12'h000;
         prev_q          <= 18'h00000;
         bsize_q         <= 8'h01;
         sel_q           <= 64'h0000000000000000;
         dgo_q           <= 1'b0;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
         if (req && avs_waitrequest) begin
            avs_readdata <= avs_read ? rmux : 32'h00000000;
         end
         // Clear is a one-cycle strobe
         ctrl_q[`IFS_CTRL_CLR] <= 1'b0;
         // Descriptor request pends until the framer is idle and picks it up
         if (state_q[4]) begin
            dgo_q <= 1'b0;
         end
         if (wr_ok) begin
            case (ridx)
               `IFS_REG_CTRL: begin
                  ctrl_q <= {24'h000000, cw[`IFS_CTRL_CLR], 1'b0, cw[5:0]};
                  if (cw[`IFS_CTRL_DGO]) begin
                     dgo_q <= 1'b1;
                  end
               end
               `IFS_REG_DESC:   desc_q  <= {8'h00, wmrg[23:0]};
               `IFS_REG_DELTA:  delta_q <= wmrg[11:0];
               `IFS_REG_PREV:   prev_q  <= wmrg[17:0];
               `IFS_REG_BSIZE:  bsize_q <= wmrg[7:0];
               `IFS_REG_SEL_LO: sel_q[31:0]  <= wmrg;
               `IFS_REG_SEL_HI: sel_q[63:32] <= wmrg;
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/ifs_section_framer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ifs_section_framer_sva (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        sec_valid,
   input wire logic [11:0] sec_payload_len,
   input wire logic [7:0]  sec_index,
   input wire logic [7:0]  sec_max_col,
   input wire logic        sec_data_end,
   input wire logic        sec_ready,
   input wire logic        pay_valid,
   input wire logic [7:0]  pay_data,
   input wire logic        pay_ready,
   input wire logic        out_valid,
   input wire logic [7:0]  out_data,
   input wire logic        out_first,
   input wire logic        out_last,
   input wire logic        out_desc,
   input wire logic        out_ready
);
   logic [15:0] cnt_q;
   // Byte position inside the unit, so header fields can be checked by place
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         cnt_q <= 16'h0000;
      else if (out_valid && out_ready)
         cnt_q <= out_last ? 16'h0000 : cnt_q + 16'h0001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_tid; out_valid && out_first && !out_desc |-> out_data == 8'h79; endproperty
   a_tid: assert property (p_tid)
      else $error("section id byte wrong");
   property p_dtag; out_valid && out_first && out_desc |-> out_data == 8'h77; endproperty
   a_dtag: assert property (p_dtag)
      else $error("descriptor tag byte wrong");
   property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last); endproperty
   a_hold: assert property (p_hold)
      else $error("output byte changed while stalled");
   property p_first; sec_valid && sec_ready && !out_valid |-> ##2 out_valid && out_first && out_data == 8'h79; endproperty
   a_first: assert property (p_first)
      else $error("section did not start two cycles after request");
   property p_pay; pay_valid && pay_ready |=> out_valid && out_data == $past(pay_data); endproperty
   a_pay: assert property (p_pay)
      else $error("payload byte not passed on");
   property p_place; out_valid |-> out_first == (cnt_q == 16'h0000); endproperty
   a_place: assert property (p_place)
      else $error("first flag out of place");
   property p_hdr1; out_valid && !out_desc && cnt_q == 16'h0001 |-> out_data[7:4] == 4'hb; endproperty
   a_hdr1: assert property (p_hdr1)
      else $error("indicator or reserved bits wrong");
   property p_hdr4; out_valid && !out_desc && cnt_q == 16'h0004 |-> out_data == 8'hff; endproperty
   a_hdr4: assert property (p_hdr4)
      else $error("reserved or current bits wrong");
   property p_dlen; out_valid && out_desc && cnt_q == 16'h0001 |-> out_data inside {8'h03, 8'h0b}; endproperty
   a_dlen: assert property (p_dlen)
      else $error("descriptor length wrong");
   property p_dfld; out_valid && out_desc && cnt_q == 16'h0002 |-> out_data[4:3] == 2'b11 && !out_data[6]; endproperty
   a_dfld: assert property (p_dfld)
      else $error("descriptor mode or reserved bits wrong");
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer late");
   c_sec: cover property (sec_valid && sec_ready);
   c_desc: cover property (out_valid && out_first && out_desc);
   c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule
bind ifs_section_framer ifs_section_framer_sva i_ifs_section_framer_sva (.clock(clock), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sec_valid(sec_valid), .sec_payload_len(sec_payload_len), .sec_index(sec_index), .sec_max_col(sec_max_col),
   .sec_data_end(sec_data_end), .sec_ready(sec_ready), .pay_valid(pay_valid), .pay_data(pay_data),
   .pay_ready(pay_ready), .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
   .out_last(out_last), .out_desc(out_desc), .out_ready(out_ready));
`default_nettype wire

// ### tb/ifs_mux_model.sv
`timescale 1ns/100ps
`default_nettype none
module ifs_mux_model (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       slow,
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_first,
   input wire logic       out_desc,
   input wire logic       out_last,
   output logic           out_ready
);
   logic [7:0]  b [0:63];
   int          n;
   int          units;
   logic        dsc;
   logic [31:0] crc_q;
   logic [3:0]  tick;
   // Residue of the section CRC taken over the check bytes too is zero
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {d, 24'h000000};
      for (int i = 0; i < 8; i++)
         r = r[31] ? {r[30:0], 1'b0} ^ 32'h04c11db7 : {r[30:0], 1'b0};
      return r;
   endfunction
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         out_ready <= 1'b0;
         tick <= 4'h0;
         n <= 0;
         units <= 0;
         dsc <= 1'b0;
         crc_q <= 32'hffffffff;
      end else begin
         tick <= tick + 4'h1;
         // Slow mode stalls three cycles in four, like a busy multiplexer
         out_ready <= !slow || tick[1:0] == 2'b11;
         if (out_valid && out_ready) begin
            b[out_first ? 0 : n[5:0]] <= out_data;
            n <= out_first ? 1 : n + 1;
            if (out_first)
               dsc <= out_desc;
            crc_q <= crc_step(out_first ? 32'hffffffff : crc_q, out_data);
            if (out_last)
               units <= units + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/ifs_section_framer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ifs_section_framer_tb_top;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sec_valid = 1'b0;
   logic [11:0] sec_payload_len = 12'h000;
   logic [7:0]  sec_index = 8'h00;
   logic        sec_data_end = 1'b0;
   logic        sec_ready;
   logic        pay_valid = 1'b0;
   logic [7:0]  pay_data = 8'h00;
   logic        pay_ready;
   logic        out_valid;
   logic [7:0]  out_data;
   logic        out_first;
   logic        out_last;
   logic        out_desc;
   logic        out_ready;
   logic        slow = 1'b0;
   logic [31:0] rd_q;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          pay_i = 0;
   int          pay_n = 0;
   always #50 clock = ~clock;
   ifs_section_framer #(.CLK_MHZ(10)) i_ifs_section_framer (.clock(clock), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sec_valid(sec_valid), .sec_payload_len(sec_payload_len), .sec_index(sec_index), .sec_max_col(8'h40),
      .sec_data_end(sec_data_end), .sec_ready(sec_ready), .pay_valid(pay_valid), .pay_data(pay_data),
      .pay_ready(pay_ready), .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
      .out_last(out_last), .out_desc(out_desc), .out_ready(out_ready));
   ifs_mux_model i_ifs_mux_model (.clock(clock), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
      .out_data(out_data), .out_first(out_first), .out_desc(out_desc), .out_last(out_last), .out_ready(out_ready));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Cut a hang short well above the expected run time
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end
   // Payload source: one byte per handshake, pattern a0, a1, ...
   always @(posedge clock) begin
      if (pay_valid && pay_ready) begin
         pay_i <= pay_i + 1;
         pay_data <= 8'ha1 + pay_i[7:0];
         pay_valid <= pay_i + 1 < pay_n;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic sec(input logic [11:0] len, input logic [7:0] idx, input logic de);
      int u;
      u = i_ifs_mux_model.units;
      @(posedge clock);
      sec_payload_len <= len;
      sec_index <= idx;
      sec_data_end <= de;
      sec_valid <= 1'b1;
      do @(posedge clock); while (sec_ready !== 1'b1);
      sec_valid <= 1'b0;
      pay_i <= 0;
      pay_n <= len;
      pay_data <= 8'ha0;
      pay_valid <= len != 12'h000;
      while (i_ifs_mux_model.units == u) @(posedge clock);
   endtask
   task automatic desc(input logic [31:0] ctrl);
      int u;
      u = i_ifs_mux_model.units;
      bus(1'b1, 5'h00, ctrl);
      while (i_ifs_mux_model.units == u) @(posedge clock);
   endtask
   task automatic chk_sec(input logic [11:0] len, input logic [7:0] bn, input logic [7:0] idx,
                          input logic [7:0] bsz, input logic [11:0] dt, input logic de, input logic lp);
      logic [95:0] h;
      h = {8'h79, 4'hb, len + 12'd13, bn, 8'hff, idx, 8'h40, bsz, dt, de, lp, 18'h2abcd};
      for (int i = 0; i < 12; i++)
         chk("header byte", h[95 - 8 * i -: 8], i_ifs_mux_model.b[i]);
      for (int i = 0; i < len; i++)
         chk("payload byte", 8'ha0 + i[7:0], i_ifs_mux_model.b[12 + i]);
      chk("section bytes", len + 16, i_ifs_mux_model.n);
      chk("crc residue", 32'h0, i_ifs_mux_model.crc_q);
      chk("unit kind", 32'h0, i_ifs_mux_model.dsc);
   endtask
   task automatic chk_desc(input logic [103:0] v, input int nb);
      for (int i = 0; i < nb; i++)
         chk("descriptor byte", v[103 - 8 * i -: 8], i_ifs_mux_model.b[i]);
      chk("descriptor bytes", nb, i_ifs_mux_model.n);
      chk("unit kind", 32'h1, i_ifs_mux_model.dsc);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, 5'h00, 32'h0);
      chk("ctrl reset", 32'h00000000, rd_q);
      bus(1'b0, 5'h04, 32'h0);
      chk("desc reset", 32'h0001ffff, rd_q);
      bus(1'b0, 5'h10, 32'h0);
      chk("bsize reset", 32'h00000001, rd_q);
      bus(1'b1, 5'h04, 32'h00011304);
      bus(1'b1, 5'h00, 32'h0000001b);
      bus(1'b1, 5'h08, 32'h00000123);
      bus(1'b1, 5'h0c, 32'h0002abcd);
      bus(1'b1, 5'h10, 32'h00000002);
      bus(1'b1, 5'h14, 32'h89abcdef);
      bus(1'b1, 5'h18, 32'h01234567);
      sec(12'h003, 8'h00, 1'b0);
      chk_sec(12'h003, 8'h00, 8'h00, 8'h02, 12'h123, 1'b0, 1'b0);
      slow <= 1'b1;
      sec(12'h005, 8'h01, 1'b1);
      chk_sec(12'h005, 8'h00, 8'h01, 8'h02, 12'h123, 1'b1, 1'b1);
      slow <= 1'b0;
      bus(1'b1, 5'h08, 32'h00000005);
      sec(12'h001, 8'h00, 1'b0);
      chk_sec(12'h001, 8'h01, 8'h00, 8'h02, 12'h00b, 1'b0, 1'b0);
      bus(1'b1, 5'h08, 32'h00000000);
      sec(12'h001, 8'h01, 1'b1);
      chk_sec(12'h001, 8'h01, 8'h01, 8'h02, 12'h000, 1'b1, 1'b1);
      desc(32'h0000005b);
      chk_desc({8'h77, 8'h0b, 8'hbb, 8'h04, 8'h31, 64'h0123456789abcdef}, 13);
      bus(1'b1, 5'h04, 32'h00010304);
      desc(32'h000000c4);
      chk_desc({8'h77, 8'h03, 8'h18, 8'hff, 8'h30, 64'h0}, 5);
      // Encoding period 100 puts the burst number wrap at 200
      bus(1'b1, 5'h04, 32'h00640304);
      bus(1'b1, 5'h10, 32'h00000001);
      bus(1'b1, 5'h00, 32'h00000080);
      for (int i = 0; i < 202; i++) begin
         sec(12'h001, 8'h00, 1'b1);
         chk_sec(12'h001, 8'(i % 200), 8'h00, 8'h01, 12'(i), 1'b1, 1'b1);
      end
      bus(1'b0, 5'h1c, 32'h0);
      chk("status", 32'h0000ca02, rd_q);
      stop_test();
   end
endmodule
`default_nettype wire
